// >>> tb_tbgsp_top.sv
`timescale 1ns/1ns
// ==========================================================
// bench
module tb_tbgsp_top;
  import tbgsp_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig, t1p, pv, cp;
  logic [7:0]  awaddr, araddr, b;
  logic [31:0] wdata, v;
  logic [1:0]  r, pc;
  logic [10:0] f;
  wire logic   awready, wready, bvalid, arready, rvalid, rxd, rxd_out, rxd_oe_n, txd_out;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          err_count, tests_run, k;
  tbgsp_top tbgsp_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trigger_pin(trig), .external_count_pin(cp), .first_timer_overflow(t1p),
    .rxd_in(rxd), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_out(txd_out));
  tbgsp_peer tbgsp_peer_i (.clk(aclk), .txd(txd_out), .rxd(rxd));
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // first timer stand-in: a pulse every fourth clock
  always @(posedge aclk) begin
    pc <= pc + 2'h1;
    t1p <= (pc == 2'h3);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rc
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // hang guard, far beyond the few thousand clocks needed
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    complete_run;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, t1p, pc} = '0;
    {awaddr, araddr, wdata, err_count, tests_run} = '0;
    {trig, cp} = 2'h3;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ADDR_SERCTL, 32'h0);
    rc(ADDR_T2CTL, 32'h0);
    rd(8'h20);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // tx on second timer, 32 clocks a bit; rx on first timer, 64
    wr(ADDR_MISC, 8'h03);
    wr(ADDR_RLDL, 8'hfe);
    wr(ADDR_RLDH, 8'hff);
    wr(ADDR_CNTL, 8'hfe);
    wr(ADDR_CNTH, 8'hff);
    wr(ADDR_SERCTL, 8'h50);
    wr(ADDR_T2CTL, 8'h14);
    fork
      begin
        wr(ADDR_SERBUF, 8'ha5);
        tbgsp_peer_i.take(10, 32, f);
      end
      begin
        tbgsp_peer_i.send(9'h03c, 8, 64);
        tbgsp_peer_i.send(9'h022, 8, 64);
      end
    join
    chk({22'h0, f[9:0]}, 32'h34a);
    repeat (20) @(posedge aclk);
    rc(ADDR_SERBUF, 32'h22);
    rc(ADDR_SERCTL, 32'h57);
    // mode 3, both ways on the second timer
    wr(ADDR_T2CTL, 8'h34);
    wr(ADDR_SERCTL, 8'hd8);
    fork
      begin
        wr(ADDR_SERBUF, 8'h96);
        tbgsp_peer_i.take(11, 32, f);
      end
      tbgsp_peer_i.send(9'h169, 9, 32);
    join
    chk({21'h0, f}, 32'h72c);
    repeat (20) @(posedge aclk);
    rc(ADDR_SERBUF, 32'h69);
    rc(ADDR_SERCTL, 32'hdf);
    rc(ADDR_T2CTL, 32'h34);
    // trigger edge in baud mode: flag only
    wr(ADDR_T2CTL, 8'h3c);
    trig <= 1'b0;
    repeat (8) @(posedge aclk);
    trig <= 1'b1;
    rc(ADDR_T2CTL, 32'h7c);
    rc(ADDR_RLDL, 32'hfe);
    // no clock select: plain reload, overflow flag comes back
    wr(ADDR_T2CTL, 8'h04);
    repeat (40) @(posedge aclk);
    rc(ADDR_T2CTL, 32'h84);
    // mode 0: data bits read at each rising shift clock
    wr(ADDR_SERCTL, 8'h00);
    wr(ADDR_SERBUF, 8'h5a);
    pv = 1'b1;
    k = 0;
    while (k < 8) begin
      @(posedge aclk);
      if (txd_out && !pv) begin
        // a pin not driven counts as a zero bit
        b[k] = rxd_out & ~rxd_oe_n;
        k++;
      end
      pv = txd_out;
    end
    chk({24'h0, b}, 32'h5a);
    repeat (10) @(posedge aclk);
    // mode 2 at double rate, 12-clock timing: 32 clocks a bit
    wr(ADDR_MISC, 8'h02);
    wr(ADDR_SERCTL, 8'h80);
    wr(ADDR_SERBUF, 8'h3c);
    tbgsp_peer_i.take(11, 32, f);
    chk({21'h0, f}, 32'h478);
    // counter on the external pin, run bit set separately
    wr(ADDR_T2CTL, 8'h02);
    wr(ADDR_CNTL, 8'hfe);
    wr(ADDR_CNTH, 8'hff);
    wr(ADDR_T2CTL, 8'h06);
    cp <= 1'b0;
    repeat (8) @(posedge aclk);
    cp <= 1'b1;
    repeat (8) @(posedge aclk);
    rc(ADDR_CNTL, 32'hff);
    cp <= 1'b0;
    repeat (8) @(posedge aclk);
    cp <= 1'b1;
    repeat (8) @(posedge aclk);
    rc(ADDR_T2CTL, 32'h86);
    complete_run;
  end
endmodule : tb_tbgsp_top

// >>> tbgsp_peer.sv
`timescale 1ns/1ns
// ==========================================================
// remote serial peer on the async lines
module tbgsp_peer (
  // clock and lines
  input wire logic clk,
  input wire logic txd,
  output logic     rxd
);
  // idle line rests high, like a pulled-up line
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input int per);
    @(posedge clk);
    for (int i = 0; i < n + 2; i++) begin
      rxd <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : d[i-1];
      repeat (per) @(posedge clk);
    end
  endtask : send
  task automatic take(input int n, input int per, output logic [10:0] f);
    f = '1;
    wait (txd === 1'b0);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (per) @(posedge clk);
    end
  endtask : take
endmodule : tbgsp_peer

// >>> tbgsp_pkg.sv
package tbgsp_pkg;
  // ==========================================================
  // bus geometry and register map (byte addresses)
  localparam int            ADDR_W      = 8;
  localparam logic [7:0]    ADDR_T2CTL  = 8'h00;
  localparam logic [7:0]    ADDR_CNTL   = 8'h04;
  localparam logic [7:0]    ADDR_CNTH   = 8'h08;
  localparam logic [7:0]    ADDR_RLDL   = 8'h0c;
  localparam logic [7:0]    ADDR_RLDH   = 8'h10;
  localparam logic [7:0]    ADDR_SERCTL = 8'h14;
  localparam logic [7:0]    ADDR_SERBUF = 8'h18;
  localparam logic [7:0]    ADDR_MISC   = 8'h1c;
  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;
  // ==========================================================
  // second_timer_control field positions
  localparam int            TC_OVF      = 7;
  localparam int            TC_EXF      = 6;
  localparam int            TC_RCLK     = 5;
  localparam int            TC_TX_CLOCK_SELECT     = 4;
  localparam int            TC_EXEN     = 3;
  localparam int            TC_RUN      = 2;
  localparam int            TC_CT       = 1;
  localparam int            TC_CP       = 0;
  // serial_control field positions
  localparam int            SC_REN      = 4;
  localparam int            SC_TX9      = 3;
  localparam int            SC_RX9      = 2;
  localparam int            SC_TI       = 1;
  localparam int            SC_RDONE    = 0;
  // misc control field positions
  localparam int            MISC_SIX    = 0;
  localparam int            MISC_SMOD   = 1;
  // ==========================================================
  // cycle counts
  localparam logic [3:0]    MC_LAST12   = 4'hb;
  localparam logic [3:0]    MC_LAST6    = 4'h5;
  localparam logic [3:0]    HALF12      = 4'h6;
  localparam logic [3:0]    HALF6       = 4'h3;
  localparam logic [3:0]    OVS_MID     = 4'h7;
  localparam logic [3:0]    OVS_LAST    = 4'hf;
  localparam logic [3:0]    BITS_M0     = 4'h8;
  localparam logic [3:0]    BITS_M1     = 4'ha;
  localparam logic [3:0]    BITS_M23    = 4'hb;
  localparam logic [3:0]    RX_SAMPLES  = 4'h9;
  localparam logic [15:0]   CNT_TOP     = 16'hffff;
  // ==========================================================
  // serial modes and sequencer states
  localparam logic [1:0]    MODE0       = 2'h0;
  localparam logic [1:0]    MODE1       = 2'h1;
  localparam logic [1:0]    MODE2       = 2'h2;
  typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_SYNC} tbgsp_tx_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} tbgsp_rx_t;
  typedef struct packed {
    logic [7:0]  t2ctl;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [7:0]  serial_control;
    logic [7:0]  rxbuf;
    logic [1:0]  misc;
    logic [3:0]  div;
    logic        st_tog;
    logic [1:0]  m2cnt;
    logic        t1half;
    logic [2:0]  exs;
    logic [2:0]  cps;
    logic [2:0]  rxs;
    logic        exf_l;
    logic        cpf_l;
    logic        rxf_l;
    tbgsp_tx_t   tx;
    logic [10:0] txsh;
    logic [3:0]  txn;
    logic [3:0]  txc;
    logic        m0go;
    tbgsp_rx_t   rx;
    logic [8:0]  rxsh;
    logic [3:0]  rxn;
    logic [3:0]  rxc;
    logic        sclk;
    logic        txd;
    logic        rxo;
    logic        rxoe_n;
    logic        aw_have;
    logic [7:0]  awa;
    logic        w_have;
    logic [7:0]  wd;
    logic        ws;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tbgsp_state_t;
  localparam tbgsp_state_t ST_RESET = '{tx: TX_IDLE, rx: RX_IDLE, txd: 1'b1, rxo: 1'b1,
    rxoe_n: 1'b1, sclk: 1'b1, exs: 3'h7, cps: 3'h7, rxs: 3'h7, exf_l: 1'b1,
    cpf_l: 1'b1, rxf_l: 1'b1, default: '0};
endpackage : tbgsp_pkg

// >>> tbgsp_props.sv
`timescale 1ns/1ns
// ==========================================================
// port checker
module tbgsp_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // serial pins
  input wire logic        rxd_oe_n,
  input wire logic        txd_out
);
  // one domain, reset masks every check
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  rst_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && txd_out && rxd_oe_n)
    else $error("outputs not idle after reset");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  txd_low_a: assert property ($fell(txd_out) |-> !txd_out [*3])
    else $error("transmit pin low too short");
  // main scenarios reached
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_c: cover property (s_axi_rvalid && s_axi_rready);
  sh_c: cover property ($fell(rxd_oe_n));
endmodule : tbgsp_props
bind tbgsp_top tbgsp_props tbgsp_props_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rxd_oe_n, .txd_out);

// >>> tbgsp_top.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Contract
// - transmit clock from first timer when select is 0, second timer when 1
// - baud mode: high byte rollover reloads the counter from reload registers
// - modes 1 and 3 on second timer: bit rate is overflow rate over 16
// - baud mode internal: count every clock (6-clock) or every second clock
// - internal rate is oscillator over n times (65536 minus reload)
// - baud mode rollover never sets the overflow flag or timer interrupt
// - baud mode trigger falling edge sets external flag, no reload
// - baud behaviour only when receive or transmit clock select is 1
// - baud count may come from external count pin, overflow over 16
// - reload on overflow (not capture mode), reload or capture on trigger edge when enabled, not baud
// - full duplex, second reception may start before first byte is read
// - buffer write loads transmitter, read returns separate receive register
// - mode 0: data on receive pin, shift clock on transmit pin, 8 bits
// - mode 1: start, eight data LSB first, stop stored as ninth bit
// - mode 2: 11-bit frames, ninth bit sent and received, fixed rates
// - mode 3 equals mode 2 with timer derived rate
// - every buffer write starts a transmission
// - mode 0 receives when done flag 0 and enable 1, else on start bit
module tbgsp_top (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address
  input  wire logic [tbgsp_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // axi4-lite write data and response
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [tbgsp_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // timer pins and first timer overflow pulse
  input  wire logic                          trigger_pin,
  input  wire logic                          external_count_pin,
  input  wire logic                          first_timer_overflow,
  // serial pins
  input  wire logic                          rxd_in,
  output logic                               rxd_out,
  output logic                               rxd_oe_n,
  output logic                               txd_out
);
  import tbgsp_pkg::*;

  // ==========================================================
  // address decode helpers
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_T2CTL) || (a == ADDR_CNTL) || (a == ADDR_CNTH) ||
               (a == ADDR_RLDL) || (a == ADDR_RLDH) || (a == ADDR_SERCTL) ||
               (a == ADDR_SERBUF) || (a == ADDR_MISC);
  endfunction : addr_hit

  // filtered level from a 3-stage synchroniser: {new level, falling edge}
  function automatic logic [1:0] filt(input logic [2:0] sy, input logic lv);
    logic chg;
    chg  = (sy[1] == sy[2]) && (sy[1] != lv);
    filt = {chg ? sy[1] : lv, chg && !sy[1]};
  endfunction : filt

  // ==========================================================
  // state
  tbgsp_state_t s_r;
  tbgsp_state_t s_nxt;
  logic [1:0]   mode;
  logic         six;
  logic         smod;
  logic         mc;
  logic         half;
  logic         ex_fall;
  logic         cp_fall;
  logic         rx_fall;
  logic [1:0]   f_ex;
  logic [1:0]   f_cp;
  logic [1:0]   f_rx;
  logic         baud;
  logic         run;
  logic         inc;
  logic         ovf;
  logic         trig;
  logic         t2_tick;
  logic         t1_tick;
  logic         m2_tick;
  logic         tx16;
  logic         rx16;
  logic         wr;
  logic [7:0]   wd;
  logic [7:0]   wa;
  logic         ti_set;
  logic         ri_set;
  logic         rb8_set;
  logic         rb8_val;
  logic [8:0]   newsh;
  logic         m0act;
  logic [7:0]   rd;

  // bus handshakes are combinational from the holding flags
  assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_have && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign rxd_out       = s_r.rxo;
  assign rxd_oe_n      = s_r.rxoe_n;
  assign txd_out       = s_r.txd;

  // ==========================================================
  // next-state logic
  always_comb begin : next_state
    s_nxt   = s_r;
    mode    = s_r.serial_control[7:6];
    six     = s_r.misc[MISC_SIX];
    smod    = s_r.misc[MISC_SMOD];
    ti_set  = 1'b0;
    ri_set  = 1'b0;
    rb8_set = 1'b0;
    rb8_val = 1'b0;
    newsh   = {s_r.rxf_l, s_r.rxsh[8:1]};

    // machine-cycle divider: 12 or 6 clocks, half mark for the shift clock
    mc   = (s_r.div == 4'h0);
    half = (s_r.div == (six ? HALF6 : HALF12));
    s_nxt.div    = (s_r.div == (six ? MC_LAST6 : MC_LAST12)) ? 4'h0 : s_r.div + 4'h1;
    s_nxt.st_tog = !s_r.st_tog;

    // pin synchronisers; only stages two and three are looked at
    s_nxt.exs = {s_r.exs[1:0], trigger_pin};
    s_nxt.cps = {s_r.cps[1:0], external_count_pin};
    s_nxt.rxs = {s_r.rxs[1:0], rxd_in};
    f_ex = filt(s_r.exs, s_r.exf_l);
    f_cp = filt(s_r.cps, s_r.cpf_l);
    f_rx = filt(s_r.rxs, s_r.rxf_l);
    s_nxt.exf_l = f_ex[1];
    s_nxt.cpf_l = f_cp[1];
    s_nxt.rxf_l = f_rx[1];
    ex_fall = f_ex[0];
    cp_fall = f_cp[0];
    rx_fall = f_rx[0];

    // register write, performed once address and data are both held
    wr = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    wa = s_r.awa;
    wd = s_r.wd;

    baud = s_r.t2ctl[TC_RCLK] || s_r.t2ctl[TC_TX_CLOCK_SELECT];
    run  = s_r.t2ctl[TC_RUN];
    inc  = s_r.t2ctl[TC_CT] ? cp_fall : (baud ? (six || s_r.st_tog) : mc);
    ovf  = run && inc && (s_r.cnt == CNT_TOP);
    trig = s_r.t2ctl[TC_EXEN] && ex_fall;
    t2_tick = ovf && baud;

    // counter advance; auto-reload and baud reload on rollover
    if (run && inc) begin
      if (ovf && (baud || !s_r.t2ctl[TC_CP])) begin
        s_nxt.cnt = s_r.rld;
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h1;
      end
    end
    if (trig && !baud) begin
      if (s_r.t2ctl[TC_CP]) begin
        s_nxt.rld = s_r.cnt;
      end else begin
        s_nxt.cnt = s_r.rld;
      end
    end

    // software writes to counter and reload registers win over hardware updates
    if (wr && s_r.ws) begin
      unique case (wa)
        ADDR_T2CTL: s_nxt.t2ctl = wd;
        ADDR_CNTL:  s_nxt.cnt[7:0] = wd;
        ADDR_CNTH:  s_nxt.cnt[15:8] = wd;
        ADDR_RLDL:  s_nxt.rld[7:0] = wd;
        ADDR_RLDH:  s_nxt.rld[15:8] = wd;
        ADDR_SERCTL: s_nxt.serial_control = wd;
        ADDR_MISC:  s_nxt.misc = wd[1:0];
        default:    s_nxt.misc = s_nxt.misc;
      endcase
    end
    if (ovf && !baud) begin
      s_nxt.t2ctl[TC_OVF] = 1'b1;
    end
    // set wins over a same-cycle software clear
    if (trig) begin
      s_nxt.t2ctl[TC_EXF] = 1'b1;
    end

    // first timer overflows: smod picks every overflow or every second one
    s_nxt.t1half = first_timer_overflow ? !s_r.t1half : s_r.t1half;
    t1_tick = first_timer_overflow && (smod || s_r.t1half);
    // mode 2 oversample tick: osc/4, osc/2 or every clock
    m2_tick = (s_r.m2cnt == 2'h0);
    if (m2_tick) begin
      s_nxt.m2cnt = {!six && !smod, !(six && smod)};
    end else begin
      s_nxt.m2cnt = s_r.m2cnt - 2'h1;
    end
    tx16 = (mode == MODE2) ? m2_tick : (s_r.t2ctl[TC_TX_CLOCK_SELECT] ? t2_tick : t1_tick);
    rx16 = (mode == MODE2) ? m2_tick : (s_r.t2ctl[TC_RCLK] ? t2_tick : t1_tick);

    // ----- transmitter
    unique case (s_r.tx)
      TX_IDLE: begin
      end
      TX_FRAME: begin
        if (tx16) begin
          s_nxt.txc = s_r.txc + 4'h1;
          if (s_r.txc == OVS_LAST) begin
            if (s_r.txn == 4'h1) begin
              s_nxt.tx = TX_IDLE;
              ti_set   = 1'b1;
            end else begin
              s_nxt.txsh = {1'b1, s_r.txsh[10:1]};
              s_nxt.txn  = s_r.txn - 4'h1;
            end
          end
        end
      end
      TX_SYNC: begin
        if (mc) begin
          s_nxt.m0go = 1'b1;
          if (s_r.m0go) begin
            if (s_r.txn == 4'h1) begin
              s_nxt.tx = TX_IDLE;
              ti_set   = 1'b1;
            end else begin
              s_nxt.txsh = {1'b1, s_r.txsh[10:1]};
              s_nxt.txn  = s_r.txn - 4'h1;
            end
          end
        end
      end
    endcase
    if (wr && s_r.ws && (wa == ADDR_SERBUF)) begin
      s_nxt.txc  = 4'h0;
      s_nxt.m0go = 1'b0;
      if (mode == MODE0) begin
        s_nxt.tx   = TX_SYNC;
        s_nxt.txsh = {3'h7, wd};
        s_nxt.txn  = BITS_M0;
      end else begin
        s_nxt.tx   = TX_FRAME;
        s_nxt.txsh = {1'b1, (mode == MODE1) ? 1'b1 : s_r.serial_control[SC_TX9], wd, 1'b0};
        s_nxt.txn  = (mode == MODE1) ? BITS_M1 : BITS_M23;
      end
    end

    // ----- receiver, independent of the transmitter except that mode 0 waits for TX_IDLE
    // full duplex receive
    unique case (s_r.rx)
      RX_IDLE: begin
        s_nxt.rxc = 4'h0;
        s_nxt.rxn = 4'h0;
        if (s_r.serial_control[SC_REN]) begin
          if (mode != MODE0 && rx_fall) begin
            s_nxt.rx = RX_START;
          end else if (mode == MODE0 && !s_r.serial_control[SC_RDONE] && s_r.tx == TX_IDLE && mc) begin
            s_nxt.rx = RX_SYNC;
          end
        end
      end
      RX_START: begin
        // a start bit that is gone at mid-bit is noise
        if (rx16) begin
          s_nxt.rxc = s_r.rxc + 4'h1;
          if (s_r.rxc == OVS_MID) begin
            s_nxt.rxc = 4'h0;
            s_nxt.rx  = s_r.rxf_l ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        // sample at mid-bit; stop bit (mode 1) or ninth bit lands in bit 8
        if (rx16) begin
          s_nxt.rxc = s_r.rxc + 4'h1;
          if (s_r.rxc == OVS_LAST) begin
            s_nxt.rxsh = newsh;
            s_nxt.rxn  = s_r.rxn + 4'h1;
            if (s_r.rxn == RX_SAMPLES - 4'h1) begin
              s_nxt.rx    = RX_IDLE;
              s_nxt.rxbuf = newsh[7:0];
              ri_set      = 1'b1;
              rb8_set     = 1'b1;
              rb8_val     = newsh[8];
            end
          end
        end
      end
      RX_SYNC: begin
        // sample on the rising shift clock edge
        if (half) begin
          s_nxt.rxsh = newsh;
          s_nxt.rxn  = s_r.rxn + 4'h1;
          if (s_r.rxn == BITS_M0 - 4'h1) begin
            s_nxt.rx    = RX_IDLE;
            s_nxt.rxbuf = newsh[8:1];
            ri_set      = 1'b1;
          end
        end
      end
    endcase
    // clearing receive enable abandons a frame in progress
    if (!s_r.serial_control[SC_REN]) begin
      s_nxt.rx = RX_IDLE;
    end
    // newest byte overwrites
    // flags set by hardware win over a same-cycle software clear
    if (ti_set) begin
      s_nxt.serial_control[SC_TI] = 1'b1;
    end
    if (ri_set) begin
      s_nxt.serial_control[SC_RDONE] = 1'b1;
    end
    if (rb8_set) begin
      s_nxt.serial_control[SC_RX9] = rb8_val;
    end

    // ----- pin drivers, registered from the next state
    m0act = (s_nxt.tx == TX_SYNC) || (s_nxt.rx == RX_SYNC);
    if (!m0act || half) begin
      s_nxt.sclk = 1'b1;
    end else if (mc) begin
      s_nxt.sclk = 1'b0;
    end
    s_nxt.rxoe_n = !(s_nxt.tx == TX_SYNC);
    s_nxt.rxo    = (s_nxt.tx == TX_SYNC) ? s_nxt.txsh[0] : 1'b1;
    if (s_nxt.tx == TX_FRAME) begin
      s_nxt.txd = s_nxt.txsh[0];
    end else begin
      s_nxt.txd = (mode == MODE0) ? s_nxt.sclk : 1'b1;
    end

    // ----- axi4-lite write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awa     = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wd     = s_axi_wdata[7:0];
      s_nxt.ws     = s_axi_wstrb[0];
    end
    if (wr) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = addr_hit(wa) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // ----- axi4-lite read; reads have no side effects
    unique case (s_axi_araddr)
      ADDR_T2CTL: rd = s_r.t2ctl;
      ADDR_CNTL:  rd = s_r.cnt[7:0];
      ADDR_CNTH:  rd = s_r.cnt[15:8];
      ADDR_RLDL:  rd = s_r.rld[7:0];
      ADDR_RLDH:  rd = s_r.rld[15:8];
      ADDR_SERCTL: rd = s_r.serial_control;
      ADDR_SERBUF: rd = s_r.rxbuf;
      ADDR_MISC:  rd = {6'h00, s_r.misc};
      default:    rd = 8'h00;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = {24'h000000, rd};
      s_nxt.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end : next_state

  // ==========================================================
  // state register, synchronous active-low reset
  always_ff @(posedge aclk) begin : state_reg
    if (!aresetn) begin
      s_r <= ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end : state_reg

endmodule : tbgsp_top
